// >>> hw/ptpc_pkg.sv
// Constants, register map and helpers of the pulse timing and power block.
// Assumes a 125 MHz system clock and a 32-bit Avalon-MM register bus.
package ptpc_pkg;
	// Widths.
	localparam int CNT_W = 16;
	localparam int DIV_W = 4;
	localparam int NPH   = 5;
	localparam int NBLK  = 4;
	localparam int ADR_W = 8;
	localparam int DAT_W = 32;
	localparam int LOW_W = 16;
	localparam int OSC_W = 5;
	// Phase windows of the timing engine.
	localparam int PH_LED  = 0;
	localparam int PH_SAMP = 1;
	localparam int PH_ARST = 2;
	localparam int PH_CONV = 3;
	localparam int PH_PDN  = 4;
	// Index of the amplifier among the dynamic block selects.
	localparam int BLK_AMP = 3;
	// Register byte offsets.
	localparam logic [ADR_W-1:0] OFS_CTRL   = 8'h00;
	localparam logic [ADR_W-1:0] OFS_DIV    = 8'h04;
	localparam logic [ADR_W-1:0] OFS_PERIOD = 8'h08;
	localparam logic [ADR_W-1:0] OFS_DYN    = 8'h0C;
	localparam logic [ADR_W-1:0] OFS_STATUS = 8'h10;
	localparam logic [ADR_W-1:0] OFS_WIN0   = 8'h20;
	// Control register fields.
	localparam int CTRL_SOFT_RST = 0;
	localparam int CTRL_SW_PD    = 1;
	localparam int CTRL_SHORT_EN = 2;
	localparam int CTRL_OSC_OUT  = 3;
	localparam int CTRL_CLK_INT  = 4;
	// Divider register fields.
	localparam int DIV_EXT_LSB = 0;
	localparam int DIV_TE_LSB  = 4;
	// Window register fields: start low half, end high half.
	localparam int WIN_END_LSB = 16;
	// Status register fields.
	localparam int STAT_HW_PD  = 16;
	localparam int STAT_SW_PD  = 17;
	localparam int STAT_PDN    = 18;
	// Reset values and the external divide limit.
	localparam logic [CNT_W-1:0] PERIOD_RST = 16'h9C3F;
	localparam logic [CNT_W-1:0] START_RST  = 16'hFFFF;
	localparam logic [CNT_W-1:0] END_RST    = 16'h0000;
	localparam logic [DIV_W-1:0] EXT_DIV_RST = 4'h1;
	localparam logic [DIV_W-1:0] TE_DIV_RST  = 4'h0;
	localparam logic [DIV_W-1:0] EXT_DIV_MAX = 4'hC;
	// Timing.
	localparam int CLK_FREQ_KHZ = 125000;
	localparam int OSC_FREQ_KHZ = 4000;
	localparam int OSC_HALF_CYC = CLK_FREQ_KHZ / (2 * OSC_FREQ_KHZ);
	localparam int PD_TIME_US   = 200;
	localparam int PD_CYC       = PD_TIME_US * CLK_FREQ_KHZ / 1000;

	// True while a count lies inside an inclusive window.
	function automatic logic in_window(input logic [CNT_W-1:0] cnt,
		input logic [CNT_W-1:0] s, input logic [CNT_W-1:0] e);
		in_window = (cnt >= s) && (cnt <= e);
	endfunction

	// Merges write data into a register under the byte enables.
	function automatic logic [DAT_W-1:0] apply_be(
		input logic [DAT_W-1:0] old, input logic [DAT_W-1:0] wd,
		input logic [3:0] be);
		logic [DAT_W-1:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[8*i +: 8] = wd[8*i +: 8];
		apply_be = r;
	endfunction
endpackage

// >>> hw/ptpc_top.sv
// Timing engine counter with power, reset and clock controls.
// Assumes an Avalon-MM master on mclk_i; pins arrive asynchronously.
// Overview of operation
// R01: Phase lasts start through end, inclusive.
// R02: Period counter runs zero to setting, wraps.
// R03: Reset pin low past 200 us powers down.
// R04: Software power-down bit powers front end down.
// R05: Timing engine makes dynamic power-down window.
// R06: Window powers down only selected blocks.
// R07: Short enable ties inputs while amplifier sleeps.
// R08: Host sets short enable with amplifier select.
// R09: Registers reset before valid operation.
// R10: Host pulses reset pin 25-50 us; registers reset.
// R11: Software reset bit resets internal registers.
// R12: Internal 4 MHz oscillator, optionally driven out.
// R13: External clock selected after reset.
// R14: Host sets external divide 1-12 for 4-6 MHz.
// R15: Sixteen-bit counter on the timing engine clock.
// R16: Timing engine divider programmable 1 to 16.
// R17: Host keeps repetition rate at least 10 Hz.
// R18: Host may place conversions after all LEDs.
// R19: LED phase may overlap earlier conversion.
// R20: Ready pulse once per repetition period.
// R21: Engine clock is converter clock over divider.
// R22: Host ends power-down window before wrap.
// R23: Converter reset precedes its conversion.
`timescale 1ns/10ps
module ptpc_top #(
	parameter int PD_CYCLES = ptpc_pkg::PD_CYC
) (
	// Clock and reset.
	input  wire logic                        mclk_i,
	input  wire logic                        resetn_i,
	// Avalon-MM slave.
	input  wire logic [ptpc_pkg::ADR_W-1:0]  avs_address_i,
	input  wire logic                        avs_read_i,
	input  wire logic                        avs_write_i,
	input  wire logic [ptpc_pkg::DAT_W-1:0]  avs_writedata_i,
	input  wire logic [3:0]                  avs_byteenable_i,
	output logic      [ptpc_pkg::DAT_W-1:0]  avs_readdata_o,
	output logic                             avs_waitrequest_o,
	// Host pins.
	input  wire logic                        active_low_reset_pin_n_i,
	input  wire logic                        clk_pin_i,
	output logic                             clk_pin_o,
	output logic                             clk_pin_oe_o,
	output logic                             ready_o,
	// Phase outputs.
	output logic                             led_o,
	output logic                             sample_o,
	output logic                             adc_rst_o,
	output logic                             conv_o,
	output logic                             dynamic_power_down_window_o,
	// Power controls.
	output logic      [ptpc_pkg::NBLK-1:0]   block_pd_o,
	output logic                             input_short_o,
	output logic                             hardware_power_down_mode_o,
	output logic                             afe_power_down_o
);
	import ptpc_pkg::*;

	localparam logic [LOW_W-1:0] PD_LIM = LOW_W'(PD_CYCLES);
	localparam logic [OSC_W-1:0] OSC_LIM = OSC_W'(OSC_HALF_CYC - 1);

	logic [1:0]       rst_sync_q;
	logic [1:0]       clk_sync_q;
	logic             clk_prev_q;
	logic [LOW_W-1:0] low_cnt_q;
	logic             hw_pd_q;
	logic             sw_rst_q;
	logic             sw_pd_q;
	logic             short_en_q;
	logic             osc_out_q;
	logic             clk_int_q;
	logic [DIV_W-1:0] ext_div_q;
	logic [DIV_W-1:0] te_div_q;
	logic [CNT_W-1:0] period_q;
	logic [NBLK-1:0]  dyn_sel_q;
	logic [CNT_W-1:0] start_q [NPH];
	logic [CNT_W-1:0] end_q [NPH];
	logic [OSC_W-1:0] osc_cnt_q;
	logic             osc_clk_q;
	logic [DIV_W-1:0] ext_cnt_q;
	logic             adc_tick_q;
	logic [DIV_W-1:0] te_cnt_q;
	logic             te_tick_q;
	logic [CNT_W-1:0] count_q;
	logic             wrap_q;
	logic             arst_done_q;
	logic             wait_q;
	logic [NPH-1:0]   win_vec;
	logic [NBLK-1:0]  block_pd_d;
	logic             pin_low;
	logic             soft_clr;
	logic             full_pd;
	logic             osc_rise;
	logic             ext_rise;
	logic             ext_hit;
	logic             wr_take;
	logic             rd_take;
	logic [DAT_W-1:0] rd_d;

	// Decodes a window register address.
	function automatic logic is_win(input logic [ADR_W-1:0] a);
		is_win = (a >= OFS_WIN0) && (a < OFS_WIN0 + ADR_W'(4 * NPH))
			&& (a[1:0] == 2'b00);
	endfunction

	function automatic int win_idx(input logic [ADR_W-1:0] a);
		win_idx = int'((a - OFS_WIN0) >> 2);
	endfunction

	assign pin_low  = !rst_sync_q[1];
	assign soft_clr = pin_low || sw_rst_q;
	assign full_pd  = hw_pd_q || sw_pd_q;
	assign wr_take  = avs_write_i && !wait_q;
	assign rd_take  = (avs_read_i || avs_write_i) && wait_q;

	// Pin synchronisers.
	always_ff @(posedge mclk_i)
	begin
		if (!resetn_i)
		begin
			rst_sync_q <= 2'b11;
			clk_sync_q <= 2'b00;
			clk_prev_q <= 1'b0;
		end
		else
		begin
			rst_sync_q <= {rst_sync_q[0], active_low_reset_pin_n_i};
			clk_sync_q <= {clk_sync_q[0], clk_pin_i};
			clk_prev_q <= clk_sync_q[1];
		end
	end

	// Hardware power-down after a long low on the reset pin.
	always_ff @(posedge mclk_i)
	begin
		if (!resetn_i || !pin_low)
		begin
			low_cnt_q <= '0;
			hw_pd_q   <= 1'b0;
		end
		else if (low_cnt_q < PD_LIM)
			low_cnt_q <= low_cnt_q + 1'b1;
		else
			hw_pd_q <= 1'b1; // [R03]
	end

	// Software reset pulse clears the registers on the next edge.
	always_ff @(posedge mclk_i)
	begin
		if (!resetn_i)
			sw_rst_q <= 1'b0;
		else
			sw_rst_q <= wr_take && avs_address_i == OFS_CTRL
				&& avs_byteenable_i[0] && avs_writedata_i[CTRL_SOFT_RST]; // [R11]
	end

	// Control registers; a pin reset or software reset clears them.
	always_ff @(posedge mclk_i)
	begin
		if (!resetn_i || soft_clr) // [R09] [R10] [R11]
		begin
			sw_pd_q    <= 1'b0;
			short_en_q <= 1'b0;
			osc_out_q  <= 1'b0;
			clk_int_q  <= 1'b0; // [R13]
			ext_div_q  <= EXT_DIV_RST;
			te_div_q   <= TE_DIV_RST;
			period_q   <= PERIOD_RST;
			dyn_sel_q  <= '0;
		end
		else if (wr_take && avs_address_i == OFS_CTRL && avs_byteenable_i[0])
		begin
			sw_pd_q    <= avs_writedata_i[CTRL_SW_PD]; // [R04]
			short_en_q <= avs_writedata_i[CTRL_SHORT_EN];
			osc_out_q  <= avs_writedata_i[CTRL_OSC_OUT];
			clk_int_q  <= avs_writedata_i[CTRL_CLK_INT];
		end
		else if (wr_take && avs_address_i == OFS_DIV && avs_byteenable_i[0])
		begin
			ext_div_q <= avs_writedata_i[DIV_EXT_LSB +: DIV_W];
			te_div_q  <= avs_writedata_i[DIV_TE_LSB +: DIV_W]; // [R16]
		end
		else if (wr_take && avs_address_i == OFS_PERIOD)
			period_q <= CNT_W'(apply_be(DAT_W'(period_q), avs_writedata_i,
				avs_byteenable_i));
		else if (wr_take && avs_address_i == OFS_DYN && avs_byteenable_i[0])
			dyn_sel_q <= avs_writedata_i[NBLK-1:0];
	end

	// Phase window bounds.
	always_ff @(posedge mclk_i)
	begin
		if (!resetn_i || soft_clr)
		begin
			for (int i = 0; i < NPH; i++)
			begin
				start_q[i] <= START_RST;
				end_q[i]   <= END_RST;
			end
		end
		else if (wr_take && is_win(avs_address_i))
		begin
			{end_q[win_idx(avs_address_i)], start_q[win_idx(avs_address_i)]}
				<= apply_be({end_q[win_idx(avs_address_i)],
				start_q[win_idx(avs_address_i)]}, avs_writedata_i,
				avs_byteenable_i);
		end
	end

	// Internal oscillator, stopped in hardware power-down.
	always_ff @(posedge mclk_i)
	begin
		if (!resetn_i || hw_pd_q)
		begin
			osc_cnt_q <= '0;
			osc_clk_q <= 1'b0;
		end
		else if (osc_cnt_q == OSC_LIM)
		begin
			osc_cnt_q <= '0;
			osc_clk_q <= !osc_clk_q; // [R12]
		end
		else
			osc_cnt_q <= osc_cnt_q + 1'b1;
	end

	assign osc_rise = (osc_cnt_q == OSC_LIM) && !osc_clk_q && !hw_pd_q;
	assign ext_rise = clk_sync_q[1] && !clk_prev_q;
	assign ext_hit  = ext_rise && (ext_cnt_q + 1'b1 >= ext_div_q
		|| ext_cnt_q + 1'b1 >= EXT_DIV_MAX);

	// Oscillator drive onto the clock pin.
	always_ff @(posedge mclk_i)
	begin
		if (!resetn_i)
		begin
			clk_pin_o    <= 1'b0;
			clk_pin_oe_o <= 1'b0;
		end
		else
		begin
			clk_pin_o    <= osc_clk_q;
			clk_pin_oe_o <= osc_out_q && !hw_pd_q; // [R12]
		end
	end

	// Converter clock: oscillator or divided external clock.
	always_ff @(posedge mclk_i)
	begin
		if (!resetn_i || soft_clr)
		begin
			ext_cnt_q  <= '0;
			adc_tick_q <= 1'b0;
		end
		else
		begin
			if (ext_hit)
				ext_cnt_q <= '0;
			else if (ext_rise)
				ext_cnt_q <= ext_cnt_q + 1'b1;
			adc_tick_q <= clk_int_q ? osc_rise : ext_hit; // [R13] [R14]
		end
	end

	// Timing engine divider.
	always_ff @(posedge mclk_i)
	begin
		if (!resetn_i || soft_clr || full_pd)
		begin
			te_cnt_q  <= '0;
			te_tick_q <= 1'b0;
		end
		else
		begin
			te_tick_q <= 1'b0;
			if (adc_tick_q && te_cnt_q >= te_div_q)
			begin
				te_cnt_q  <= '0;
				te_tick_q <= 1'b1; // [R16] [R21]
			end
			else if (adc_tick_q)
				te_cnt_q <= te_cnt_q + 1'b1;
		end
	end

	// Repetition period counter.
	always_ff @(posedge mclk_i)
	begin
		if (!resetn_i || soft_clr)
		begin
			count_q <= '0;
			wrap_q  <= 1'b0;
		end
		else
		begin
			wrap_q <= 1'b0;
			if (te_tick_q && count_q >= period_q)
			begin
				count_q <= '0; // [R02]
				wrap_q  <= 1'b1;
			end
			else if (te_tick_q)
				count_q <= count_q + 1'b1; // [R15]
		end
	end

	// Phase window generators.
	ptpc_win_if wif [NPH] ();
	generate
		for (genvar g = 0; g < NPH; g++)
		begin : g_win
			assign wif[g].count     = count_q;
			assign wif[g].start_cnt = start_q[g];
			assign wif[g].end_cnt   = end_q[g];
			assign wif[g].clr       = full_pd || soft_clr;
			assign win_vec[g]       = wif[g].win;
			ptpc_win u_win (
				.mclk_i   (mclk_i),
				.resetn_i (resetn_i),
				.bus      (wif[g])
			);
		end
	endgenerate

	// Converter reset must end before its conversion opens.
	always_ff @(posedge mclk_i)
	begin
		if (!resetn_i || soft_clr || wrap_q)
			arst_done_q <= 1'b0;
		else if (win_vec[PH_ARST])
			arst_done_q <= 1'b0;
		else if (adc_rst_o)
			arst_done_q <= 1'b1; // [R23]
	end

	always_comb
	begin
		if (full_pd)
			block_pd_d = '1; // [R03] [R04]
		else if (win_vec[PH_PDN])
			block_pd_d = dyn_sel_q; // [R05] [R06]
		else
			block_pd_d = '0;
	end

	// Phase and power outputs; windows are independent so they may overlap.
	always_ff @(posedge mclk_i)
	begin
		if (!resetn_i)
		begin
			led_o                       <= 1'b0;
			sample_o                    <= 1'b0;
			adc_rst_o                   <= 1'b0;
			conv_o                      <= 1'b0;
			dynamic_power_down_window_o <= 1'b0;
			block_pd_o                  <= '0;
			input_short_o               <= 1'b0;
			hardware_power_down_mode_o  <= 1'b0;
			afe_power_down_o            <= 1'b0;
			ready_o                     <= 1'b0;
		end
		else
		begin
			led_o                       <= win_vec[PH_LED]; // [R19]
			sample_o                    <= win_vec[PH_SAMP];
			adc_rst_o                   <= win_vec[PH_ARST];
			conv_o                      <= win_vec[PH_CONV] && arst_done_q;
			dynamic_power_down_window_o <= win_vec[PH_PDN]; // [R05]
			block_pd_o                  <= block_pd_d;
			input_short_o <= short_en_q && block_pd_d[BLK_AMP]; // [R07]
			hardware_power_down_mode_o  <= hw_pd_q;
			afe_power_down_o            <= full_pd;
			ready_o                     <= wrap_q; // [R20]
		end
	end

	// Register read mux; unmapped addresses read zero.
	always_comb
	begin
		rd_d = '0;
		if (avs_address_i == OFS_CTRL)
		begin
			rd_d[CTRL_SW_PD]    = sw_pd_q;
			rd_d[CTRL_SHORT_EN] = short_en_q;
			rd_d[CTRL_OSC_OUT]  = osc_out_q;
			rd_d[CTRL_CLK_INT]  = clk_int_q;
		end
		else if (avs_address_i == OFS_DIV)
		begin
			rd_d[DIV_EXT_LSB +: DIV_W] = ext_div_q;
			rd_d[DIV_TE_LSB +: DIV_W]  = te_div_q;
		end
		else if (avs_address_i == OFS_PERIOD)
			rd_d[CNT_W-1:0] = period_q;
		else if (avs_address_i == OFS_DYN)
			rd_d[NBLK-1:0] = dyn_sel_q;
		else if (avs_address_i == OFS_STATUS)
		begin
			rd_d[CNT_W-1:0]  = count_q;
			rd_d[STAT_HW_PD] = hw_pd_q;
			rd_d[STAT_SW_PD] = sw_pd_q;
			rd_d[STAT_PDN]   = dynamic_power_down_window_o;
		end
		else if (is_win(avs_address_i))
			rd_d = {end_q[win_idx(avs_address_i)],
				start_q[win_idx(avs_address_i)]};
	end

	// Bus handshake: one wait cycle, then the access completes.
	always_ff @(posedge mclk_i)
	begin
		if (!resetn_i)
		begin
			wait_q         <= 1'b1;
			avs_readdata_o <= '0;
		end
		else
		begin
			wait_q <= !rd_take;
			if (rd_take)
				avs_readdata_o <= rd_d;
		end
	end

	assign avs_waitrequest_o = wait_q;

	a_ready_pulse: assert property (@(posedge mclk_i) // [R20]
		disable iff (!resetn_i) wrap_q |=> ready_o ##1 !ready_o)
		else $error("Ready is not a single pulse per wrap.");

	a_period_wrap: assert property (@(posedge mclk_i) // [R02]
		disable iff (!resetn_i)
		te_tick_q && count_q >= period_q && !soft_clr |=> count_q == '0)
		else $error("Period counter did not wrap to zero.");

	a_count_step: assert property (@(posedge mclk_i) // [R15]
		disable iff (!resetn_i)
		te_tick_q && count_q < period_q && !soft_clr
		|=> count_q == $past(count_q) + 1'b1)
		else $error("Period counter did not advance by one.");

	a_te_divide: assert property (@(posedge mclk_i) // [R16]
		disable iff (!resetn_i)
		adc_tick_q && te_cnt_q < te_div_q && !soft_clr && !full_pd
		|=> !te_tick_q && te_cnt_q == $past(te_cnt_q) + 1'b1)
		else $error("Engine tick too soon for the divider.");

	a_sw_power: assert property (@(posedge mclk_i) // [R04]
		disable iff (!resetn_i)
		sw_pd_q |=> block_pd_o == '1 && afe_power_down_o)
		else $error("Software power-down left a block awake.");

	a_hw_power: assert property (@(posedge mclk_i) // [R03]
		disable iff (!resetn_i)
		pin_low && low_cnt_q == PD_LIM |=> hw_pd_q ##1
		hardware_power_down_mode_o)
		else $error("Long reset pin low did not power down.");

	a_dyn_select: assert property (@(posedge mclk_i) // [R06]
		disable iff (!resetn_i)
		win_vec[PH_PDN] && !full_pd |=> block_pd_o == $past(dyn_sel_q))
		else $error("Dynamic window powered the wrong blocks.");

	a_input_short: assert property (@(posedge mclk_i) // [R07]
		disable iff (!resetn_i)
		input_short_o == ($past(short_en_q) && block_pd_o[BLK_AMP]))
		else $error("Input short does not follow amplifier power.");

	a_soft_reset: assert property (@(posedge mclk_i) // [R11]
		disable iff (!resetn_i)
		sw_rst_q |=> period_q == PERIOD_RST && !clk_int_q)
		else $error("Software reset left registers set.");

	a_conv_order: assert property (@(posedge mclk_i) // [R23]
		disable iff (!resetn_i) $rose(conv_o) |-> !adc_rst_o)
		else $error("Conversion opened during converter reset.");
endmodule

// >>> hw/ptpc_win.sv
// One phase window of the timing engine, registered.
// Assumes the count and bounds come from logic on the same clock.
`timescale 1ns/10ps
module ptpc_win (
	// Clock and reset.
	input  wire logic mclk_i,
	input  wire logic resetn_i,
	// Window bus.
	ptpc_win_if.wgen  bus
);
	import ptpc_pkg::*;

	logic win_q;

	always_ff @(posedge mclk_i)
	begin
		if (!resetn_i || bus.clr)
			win_q <= 1'b0;
		else
			win_q <= in_window(bus.count, bus.start_cnt, bus.end_cnt); // [R01]
	end

	assign bus.win = win_q;

	a_win_inclusive: assert property (@(posedge mclk_i) // [R01]
		disable iff (!resetn_i)
		!bus.clr && in_window(bus.count, bus.start_cnt, bus.end_cnt)
		##1 !bus.clr |-> bus.win)
		else $error("Window low inside its start and end counts.");
endmodule

// >>> hw/ptpc_win_if.sv
// Interface joining the counter core to one phase window generator.
// Assumes all signals belong to the single system clock.
`timescale 1ns/10ps
interface ptpc_win_if;
	import ptpc_pkg::*;
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] start_cnt;
	logic [CNT_W-1:0] end_cnt;
	logic             clr;
	logic             win;
	modport ctl  (output count, output start_cnt, output end_cnt,
		output clr, input win);
	modport wgen (input count, input start_cnt, input end_cnt,
		input clr, output win);
endinterface

// >>> verification/ptpc_host_model.sv
// Host microcontroller model: reset pin and a free-running clock.
// Assumes the bench resolves the two-way clock pin from both enables.
`timescale 1ns/10ps
module ptpc_host_model #(
	parameter int HALF_CYC = 2
) (
	// Clock.
	input  wire logic mclk_i,
	// Pins driven by the host.
	output logic      reset_pin_n_o,
	output logic      ext_clk_o
);
	int div_q = 0;
	initial
	begin
		reset_pin_n_o = 1'b1;
		ext_clk_o     = 1'b0;
	end
	// Clock of 31.25 MHz, so ratios 6 and 7 land in range.
	always @(posedge mclk_i)
	begin
		div_q <= (div_q == HALF_CYC - 1) ? 0 : div_q + 1;
		if (div_q == HALF_CYC - 1)
			ext_clk_o <= ~ext_clk_o;
	end
	// Pulls the reset pin low for a number of cycles.
	task automatic pin_low(input int cyc);
		@(posedge mclk_i);
		reset_pin_n_o <= 1'b0;
		repeat (cyc) @(posedge mclk_i);
		reset_pin_n_o <= 1'b1;
	endtask
endmodule

// >>> verification/pulse_timing_power_control_test.sv
// Self-checking bench of the pulse timing and power control block.
// Assumes the host model drives the reset pin and the external clock.
`timescale 1ns/10ps
module pulse_timing_power_control_test;
	import ptpc_pkg::*;
	localparam int PD_SIM = 200;
	logic             mclk_i = 1'b0;
	logic             resetn_i = 1'b0;
	logic [ADR_W-1:0] adr = '0;
	logic             rd_r = 1'b0;
	logic             wr_r = 1'b0;
	logic [DAT_W-1:0] wd = '0;
	logic [DAT_W-1:0] rdata, rd;
	logic             wreq, pin_n, hclk, cko, coe, ready_o, hw_pd, afe_pd;
	logic             led_o, samp, adc_rst_o, conv_o, pdw, ishort;
	logic             hdrv = 1'b1;
	logic [NBLK-1:0]  bpd;
	logic             lprev = 1'b0;
	logic             rarm = 1'b0;
	logic             a_hi, a_end, c_hi, c_ok, ovl;
	int               error_cnt = 0;
	int               checks = 0;
	int               rcnt = 0;
	int               lcnt = 0;
	int               n, p, sc;
	int               rdy_q[$];
	int               led_q[$];
	logic [3:0]       ex[4] = '{4'h6, 4'h7, 4'h7, 4'h6};
	logic [3:0]       tm[4] = '{4'h0, 4'h0, 4'hF, 4'h2};
	logic [ADR_W-1:0] ra[5] = '{OFS_CTRL, OFS_DIV, OFS_PERIOD, OFS_WIN0, 8'h40};
	logic [DAT_W-1:0] rv[5] = '{32'h0000_0000, 32'h0000_0001, 32'h0000_9C3F,
		32'h0000_FFFF, 32'h0000_0000};
	logic [DAT_W-1:0] wv[5] = '{32'h0006_0004, 32'h0002_0001, 32'h0003_0002,
		32'h0006_0005, 32'h0008_0007};
	wire              clk_wire = coe ? cko : (hdrv ? hclk : ~hclk);

	initial
		forever #4 mclk_i = ~mclk_i;

	ptpc_top #(.PD_CYCLES(PD_SIM)) u_dut (
		.mclk_i(mclk_i), .resetn_i(resetn_i), .avs_address_i(adr),
		.avs_read_i(rd_r), .avs_write_i(wr_r), .avs_writedata_i(wd),
		.avs_byteenable_i(4'hF), .avs_readdata_o(rdata),
		.avs_waitrequest_o(wreq), .active_low_reset_pin_n_i(pin_n),
		.clk_pin_i(clk_wire), .clk_pin_o(cko), .clk_pin_oe_o(coe),
		.ready_o(ready_o), .led_o(led_o), .sample_o(samp),
		.adc_rst_o(adc_rst_o), .conv_o(conv_o),
		.dynamic_power_down_window_o(pdw), .block_pd_o(bpd),
		.input_short_o(ishort), .hardware_power_down_mode_o(hw_pd),
		.afe_power_down_o(afe_pd));

	ptpc_host_model #(.HALF_CYC(2)) u_host (
		.mclk_i(mclk_i), .reset_pin_n_o(pin_n), .ext_clk_o(hclk));

	task automatic chk(input string what, input logic [DAT_W-1:0] seen,
		input logic [DAT_W-1:0] exp);
		checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic bus(input logic w, input logic [ADR_W-1:0] a,
		input logic [DAT_W-1:0] d);
		int k;
		k = 0;
		@(posedge mclk_i);
		adr  <= a;
		wd   <= d;
		wr_r <= w;
		rd_r <= ~w;
		do
		begin
			@(posedge mclk_i);
			k++;
		end
		while (wreq !== 1'b0 && k < 100);
		rd = rdata;
		wr_r <= 1'b0;
		rd_r <= 1'b0;
		if (k >= 100)
			error_cnt++;
	endtask

	task automatic wait_for(ref logic s, input logic v);
		int k;
		k = 0;
		do
		begin
			@(negedge mclk_i);
			k++;
		end
		while (s !== v && k < 5000);
		if (k >= 5000)
			error_cnt++;
	endtask

	// Notes one expected period and waits until the monitor has taken it.
	task automatic per_chk(input int exp);
		int k;
		k = 0;
		wait_for(ready_o, 1'b1);
		rdy_q.push_back(exp);
		while (rdy_q.size() > 0 && k < 20000)
		begin
			@(negedge mclk_i);
			k++;
		end
		if (k >= 20000)
			error_cnt++;
	endtask

	task automatic end_sim();
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Takes the oldest noted period or width when one completes.
	always @(negedge mclk_i)
	begin
		rcnt = rcnt + 1;
		lcnt = lcnt + (led_o === 1'b1);
		if (ready_o === 1'b1)
		begin
			if (rarm && rdy_q.size() > 0)
				chk("ready period", rcnt, rdy_q.pop_front());
			rarm = rdy_q.size() > 0;
			rcnt = 0;
		end
		if (lprev && led_o === 1'b0 && led_q.size() > 0)
			chk("led width", lcnt, led_q.pop_front());
		if (led_o !== 1'b1)
			lcnt = 0;
		lprev = (led_o === 1'b1);
	end

	initial
	begin
		#(8 * 90000);
		error_cnt++;
		end_sim();
	end

	initial
	begin
		void'($urandom(86445));
		repeat (6) @(posedge mclk_i);
		resetn_i <= 1'b1;
		u_host.pin_low(40);
		repeat (4) @(posedge mclk_i);
		bus(1'b1, 8'h40, $urandom());
		for (int i = 0; i < 5; i++)
		begin
			bus(1'b0, ra[i], 32'h0000_0000);
			chk("reset value", rd, rv[i]);
		end
		chk("clock pin enable", coe, 1'b0);
		$display("test reset values done");
		for (int i = 0; i < 4; i++)
		begin
			p = (i == 0) ? 40 + $urandom() % 8 : 2 + $urandom() % 4;
			bus(1'b1, OFS_PERIOD, p);
			bus(1'b1, OFS_DIV, {24'h0000_00, tm[i], ex[i]});
			per_chk((p + 1) * 4 * ex[i] * (tm[i] + 1));
		end
		$display("test period and dividers done");
		bus(1'b1, OFS_PERIOD, 32'h0000_0009);
		bus(1'b1, OFS_DIV, 32'h0000_0006);
		for (int i = 0; i < 5; i++)
			bus(1'b1, ADR_W'(OFS_WIN0 + 4 * i), wv[i]);
		wait_for(ready_o, 1'b1);
		led_q.push_back(3 * 24);
		{a_hi, a_end, c_hi, c_ok, ovl} = '0;
		sc = 0;
		for (int k = 0; k < 240; k++)
		begin
			@(negedge mclk_i);
			a_hi = a_hi | (adc_rst_o === 1'b1);
			a_end = a_end | (a_hi && adc_rst_o === 1'b0);
			if (conv_o === 1'b1 && !c_hi)
				c_ok = a_end;
			c_hi = c_hi | (conv_o === 1'b1);
			ovl = ovl | (conv_o === 1'b1 && led_o === 1'b1);
			sc = sc + (samp === 1'b1);
		end
		chk("conversion after reset", c_ok, 1'b1);
		chk("led overlaps conversion", ovl, 1'b1);
		chk("sample width", sc, 2 * 24);
		$display("test phase windows done");
		bus(1'b1, ADR_W'(OFS_WIN0 + 12), 32'h0008_0007);
		// Short enable goes with the amplifier select.
		bus(1'b1, OFS_DYN, 32'h0000_000A);
		bus(1'b1, OFS_CTRL, 32'h0000_0004);
		for (int j = 0; j < 2; j++)
		begin
			wait_for(pdw, 1'b1);
			repeat (2) @(negedge mclk_i);
			chk("blocks down", bpd, j ? 4'h1 : 4'hA);
			chk("input short", ishort, !j);
			n = 2;
			while (pdw === 1'b1 && n < 500)
			begin
				@(negedge mclk_i);
				n++;
			end
			chk("window width", n, 48);
			repeat (2) @(negedge mclk_i);
			chk("blocks awake", {ishort, bpd}, 5'h00);
			bus(1'b1, OFS_DYN, 32'h0000_0001);
		end
		$display("test dynamic power-down done");
		bus(1'b1, OFS_CTRL, 32'h0000_0002);
		c_hi = 1'b0;
		repeat (300)
		begin
			@(negedge mclk_i);
			c_hi = c_hi | (led_o === 1'b1);
		end
		chk("software power-down", {afe_pd, c_hi}, 2'b10);
		bus(1'b1, OFS_CTRL, 32'h0000_0001);
		bus(1'b0, OFS_PERIOD, 32'h0000_0000);
		chk("software reset", rd, rv[2]);
		$display("test software controls done");
		bus(1'b1, OFS_PERIOD, 32'h0000_0005);
		u_host.pin_low(40);
		repeat (4) @(negedge mclk_i);
		bus(1'b0, OFS_PERIOD, 32'h0000_0000);
		chk("pin reset", rd, rv[2]);
		chk("pin reset power", hw_pd, 1'b0);
		fork
			u_host.pin_low(PD_SIM + 60);
		join_none
		repeat (190) @(negedge mclk_i);
		chk("power-down early", hw_pd, 1'b0);
		repeat (40) @(negedge mclk_i);
		chk("power-down late", hw_pd, 1'b1);
		repeat (60) @(negedge mclk_i);
		chk("power-down ends", hw_pd, 1'b0);
		$display("test reset pin done");
		@(posedge mclk_i);
		hdrv <= 1'b0;
		bus(1'b1, OFS_CTRL, 32'h0000_0018);
		wait_for(cko, 1'b1);
		wait_for(cko, 1'b0);
		n = 0;
		while (cko !== 1'b1 && n < 100)
		begin
			@(negedge mclk_i);
			n++;
		end
		chk("oscillator half period", {coe, n[7:0]}, {1'b1, 8'(OSC_HALF_CYC)});
		bus(1'b1, OFS_PERIOD, 32'h0000_0003);
		per_chk(4 * 2 * OSC_HALF_CYC);
		$display("test oscillator done");
		end_sim();
	end
endmodule
